// ---- verilog/descriptor_table_gate_check_consts.svh ----
// Constants for the descriptor table and gate check block
//Function
//RULE1: Gate type 4 call, 5 task, 6 interrupt, 7 trap.
//RULE2: Interrupt gate entry clears interrupt enable; trap gate leaves it alone.
//RULE3: Call, interrupt or trap gate target not a code segment raises exception 13.
//RULE4: Task gate target must be a task state segment; its offset is ignored.
//RULE5: Call gate with privilege change copies word count 0-31; others ignore it.
//RULE6: Gate with present bit clear raises exception 11; set means valid.
//RULE7: Access byte bit 4 zero marks a system descriptor, same layout for all.
//RULE8: Four segment registers each refill a hidden cache on every selector load.
//RULE9: References use cached contents only; caches change only on loads, never stored.
//RULE10: Only code or data descriptors may enter a segment cache.
//RULE11: Selector bits 1-0 are the requested privilege level.
//RULE12: Selector bit 2 picks global table when zero, local table when one.
//RULE13: Selector bits 15-3 are a 13-bit index into up to 8192 entries.
//RULE14: Tables have 24-bit base and 16-bit limit; overrun raises exception 13.
//RULE15: Global table forbids interrupt and trap gates; local holds segment, task, call only.
//RULE16: Table load instructions run only at current privilege level 0.
//RULE17: Global table load fetches six bytes: 16-bit limit and 24-bit base.
//RULE18: Local table load fetches the selected table descriptor and loads base, limit.
//RULE19: Gates give 16-bit target selector and offset; entry only at that offset.
//RULE20: Local table descriptor supplies 24-bit base and 16-bit limit.
//RULE21: Entry address is base plus index times eight; last byte checked against limit.
//RULE22: Reserved descriptor word is ignored when decoding.
`ifndef DESCRIPTOR_TABLE_GATE_CHECK_CONSTS_SVH
`define DESCRIPTOR_TABLE_GATE_CHECK_CONSTS_SVH

`define DTGC_OFS_CMD 8'h00
`define DTGC_OFS_SEL 8'h04
`define DTGC_OFS_OPADDR 8'h08
`define DTGC_OFS_MODE 8'h0C
`define DTGC_OFS_GDT_BASE 8'h10
`define DTGC_OFS_GDT_LIMIT 8'h14
`define DTGC_OFS_LDT_BASE 8'h18
`define DTGC_OFS_LDT_LIMIT 8'h1C
`define DTGC_OFS_GATE_PTR 8'h20
`define DTGC_OFS_GATE_INFO 8'h24

`define DTGC_OP_LOAD_SEG 3'h0
`define DTGC_OP_GATE 3'h1
`define DTGC_OP_LOAD_GLOBAL 3'h2
`define DTGC_OP_LOAD_LOCAL 3'h3
`define DTGC_OP_VECTOR_GATE 3'h4

`define DTGC_TYPE_TSS_FREE 4'h1
`define DTGC_TYPE_LOCAL_TABLE 4'h2
`define DTGC_TYPE_TSS_BUSY 4'h3
`define DTGC_TYPE_CALL_GATE 4'h4
`define DTGC_TYPE_TASK_GATE 4'h5
`define DTGC_TYPE_INT_GATE 4'h6
`define DTGC_TYPE_TRAP_GATE 4'h7

`define DTGC_ACC_PRESENT 7
`define DTGC_ACC_SEGMENT 4
`define DTGC_ACC_EXEC 3
`define DTGC_ACC_EXPAND_DOWN 2
`define DTGC_SEL_TABLE 2

`define DTGC_EXC_NOT_PRESENT 8'h0B
`define DTGC_EXC_GENERAL 8'h0D
`define DTGC_WORD_STEP 24'h000002
`define DTGC_LAST_WORD 2'h2

`endif

// ---- verilog/dtgc_pkg.sv ----
// Types for the descriptor table and gate check block
`default_nettype none
package dtgc_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EVAL} state_type;

	typedef struct packed {
		logic valid;
		logic [23:0] base;
		logic [15:0] limit;
		logic [7:0] access;
	} cache_type;

endpackage
`default_nettype wire

// ---- verilog/descriptor_table_gate_check.sv ----
// Selector decode, descriptor table walk, gate validation and segment caches
`timescale 1ns/10ps
`default_nettype none
`include "descriptor_table_gate_check_consts.svh"
module descriptor_table_gate_check (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	output logic mem_req_out,
	output logic [23:0] mem_addr_out,
	input wire logic [15:0] mem_rdata_in,
	input wire logic mem_ack_in,
	input wire logic ref_valid_in,
	input wire logic [1:0] ref_seg_in,
	input wire logic [15:0] ref_offset_in,
	output logic phys_valid_out,
	output logic phys_fault_out,
	output logic [23:0] phys_addr_out,
	output logic busy_out,
	output logic exc_pulse_out,
	output logic [7:0] exc_vector_out,
	output logic if_flag_out,
	output logic [4:0] gate_copy_count_out
);

	typedef struct packed {
		dtgc_pkg::state_type state;
		logic busy;
		logic phase;
		logic [1:0] word_cnt;
		logic [2:0] op;
		logic [1:0] seg;
		logic priv_change;
		logic [15:0] sel;
		logic [15:0] dest_sel;
		logic [23:0] op_addr;
		logic [1:0] current_priv_level;
		logic if_flag;
		logic [23:0] gdt_base;
		logic [15:0] gdt_limit;
		logic [23:0] ldt_base;
		logic [15:0] ldt_limit;
		logic [15:0] word0;
		logic [15:0] word1;
		logic [15:0] word2;
		logic mem_req;
		logic [23:0] mem_addr;
		logic [31:0] rdata;
		logic exc_pulse;
		logic exc_flag;
		logic done;
		logic [7:0] exc_vec;
		logic [2:0] gate_kind;
		logic [15:0] gate_sel;
		logic [15:0] gate_off;
		logic [4:0] copy_cnt;
		dtgc_pkg::cache_type [3:0] cache;
		logic phys_valid;
		logic phys_fault;
		logic [23:0] phys_addr;
	} state_all_type;

	state_all_type r;
	state_all_type next_r;

	// Returns {fault, entry address}; the whole eight-byte entry must fit under the limit
	function automatic logic [24:0] locate(input logic [15:0] sel, input logic [23:0] gbase,
		input logic [15:0] glim, input logic [23:0] lbase, input logic [15:0] llim);
		logic [23:0] tbase;
		logic [15:0] tlim;
		logic [15:0] last_byte;
		tbase = sel[`DTGC_SEL_TABLE] ? lbase : gbase; // RULE12
		tlim = sel[`DTGC_SEL_TABLE] ? llim : glim; // RULE14
		last_byte = {sel[15:3], 3'b111}; // RULE13 RULE21
		locate = {last_byte > tlim, tbase + {8'h00, sel[15:3], 3'b000}}; // RULE21 RULE14
	endfunction

	function automatic logic is_gate(input logic [7:0] acc);
		is_gate = !acc[`DTGC_ACC_SEGMENT] && acc[3:0] >= `DTGC_TYPE_CALL_GATE
			&& acc[3:0] <= `DTGC_TYPE_TRAP_GATE; // RULE1 RULE7
	endfunction

	logic [24:0] hit;
	logic [7:0] acc;
	logic [3:0] dtype;
	logic table_bad;
	dtgc_pkg::cache_type rc;

	always_comb
	begin
		next_r = r;
		hit = 25'h0000000;
		acc = r.word2[15:8];
		dtype = acc[3:0];
		table_bad = 1'b0;
		rc = r.cache[ref_seg_in];
		next_r.exc_pulse = 1'b0;
		next_r.phys_valid = 1'b0;
		next_r.rdata = 32'h00000000;

		// Register writes; the engine below runs afterwards so its updates win
		if (reg_write_in)
		begin
			case (reg_addr_in)
				`DTGC_OFS_SEL:
					if (!r.busy)
						next_r.sel = reg_wdata_in[15:0];
				`DTGC_OFS_OPADDR:
					if (!r.busy)
						next_r.op_addr = reg_wdata_in[23:0];
				`DTGC_OFS_MODE:
				begin
					next_r.current_priv_level = reg_wdata_in[1:0];
					next_r.if_flag = reg_wdata_in[4];
				end
				default:
					next_r.op = next_r.op;
			endcase
		end

		if (reg_read_in)
		begin
			case (reg_addr_in)
				`DTGC_OFS_CMD:
					next_r.rdata = {21'h000000, r.busy, r.done, r.exc_flag, r.exc_vec};
				`DTGC_OFS_SEL:
					next_r.rdata = {16'h0000, r.sel};
				`DTGC_OFS_OPADDR:
					next_r.rdata = {8'h00, r.op_addr};
				`DTGC_OFS_MODE:
					next_r.rdata = {27'h0000000, r.if_flag, 2'b00, r.current_priv_level};
				`DTGC_OFS_GDT_BASE:
					next_r.rdata = {8'h00, r.gdt_base};
				`DTGC_OFS_GDT_LIMIT:
					next_r.rdata = {16'h0000, r.gdt_limit};
				`DTGC_OFS_LDT_BASE:
					next_r.rdata = {8'h00, r.ldt_base};
				`DTGC_OFS_LDT_LIMIT:
					next_r.rdata = {16'h0000, r.ldt_limit};
				`DTGC_OFS_GATE_PTR:
					next_r.rdata = {r.gate_off, r.gate_sel};
				`DTGC_OFS_GATE_INFO:
					next_r.rdata = {14'h0000, r.sel[1:0], 3'b000, r.copy_cnt, 5'h00,
						r.gate_kind}; // RULE11
				default:
					next_r.rdata = 32'h00000000;
			endcase
		end

		// References only ever read the caches, never memory
		if (ref_valid_in)
		begin
			next_r.phys_valid = 1'b1; // RULE9
			next_r.phys_addr = rc.base + {8'h00, ref_offset_in}; // RULE9
			if (!rc.valid)
				next_r.phys_fault = 1'b1;
			else if (!rc.access[`DTGC_ACC_EXEC] && rc.access[`DTGC_ACC_EXPAND_DOWN])
				next_r.phys_fault = ref_offset_in <= rc.limit;
			else
				next_r.phys_fault = ref_offset_in > rc.limit;
		end

		case (r.state)
			dtgc_pkg::ST_IDLE:
			begin
				if (reg_write_in && reg_addr_in == `DTGC_OFS_CMD)
				begin
					next_r.op = reg_wdata_in[2:0];
					next_r.seg = reg_wdata_in[5:4];
					next_r.priv_change = reg_wdata_in[8];
					next_r.done = 1'b0;
					next_r.exc_flag = 1'b0;
					next_r.exc_vec = 8'h00;
					next_r.phase = 1'b0;
					next_r.word_cnt = 2'h0;
					hit = locate(r.sel, r.gdt_base, r.gdt_limit, r.ldt_base, r.ldt_limit);
					if ((reg_wdata_in[2:0] == `DTGC_OP_LOAD_GLOBAL
						|| reg_wdata_in[2:0] == `DTGC_OP_LOAD_LOCAL)
						&& r.current_priv_level != 2'b00) // RULE16
					begin
						next_r.exc_pulse = 1'b1;
						next_r.exc_flag = 1'b1;
						next_r.exc_vec = `DTGC_EXC_GENERAL;
						next_r.done = 1'b1;
					end
					else if (reg_wdata_in[2:0] == `DTGC_OP_LOAD_GLOBAL
						|| reg_wdata_in[2:0] == `DTGC_OP_VECTOR_GATE)
					begin
						next_r.mem_addr = r.op_addr; // RULE17
						next_r.mem_req = 1'b1;
						next_r.busy = 1'b1;
						next_r.state = dtgc_pkg::ST_FETCH;
					end
					else if (hit[24] || (reg_wdata_in[2:0] == `DTGC_OP_LOAD_LOCAL
						&& r.sel[`DTGC_SEL_TABLE])) // RULE14 RULE18
					begin
						next_r.exc_pulse = 1'b1;
						next_r.exc_flag = 1'b1;
						next_r.exc_vec = `DTGC_EXC_GENERAL;
						next_r.done = 1'b1;
					end
					else
					begin
						next_r.mem_addr = hit[23:0];
						next_r.mem_req = 1'b1;
						next_r.busy = 1'b1;
						next_r.state = dtgc_pkg::ST_FETCH;
					end
				end
			end

			// Three words are read; the fourth word is reserved and never fetched
			dtgc_pkg::ST_FETCH:
			begin
				if (mem_ack_in)
				begin
					case (r.word_cnt)
						2'h0:
							next_r.word0 = mem_rdata_in;
						2'h1:
							next_r.word1 = mem_rdata_in;
						default:
							next_r.word2 = mem_rdata_in;
					endcase
					if (r.word_cnt == `DTGC_LAST_WORD) // RULE22
					begin
						next_r.mem_req = 1'b0;
						next_r.state = dtgc_pkg::ST_EVAL;
					end
					else
					begin
						next_r.word_cnt = r.word_cnt + 2'h1;
						next_r.mem_addr = r.mem_addr + `DTGC_WORD_STEP;
					end
				end
			end

			dtgc_pkg::ST_EVAL:
			begin
				next_r.state = dtgc_pkg::ST_IDLE;
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				next_r.exc_vec = 8'h00;
				case (r.op)
					`DTGC_OP_LOAD_GLOBAL:
					begin
						next_r.gdt_limit = r.word0; // RULE17
						next_r.gdt_base = {r.word2[7:0], r.word1}; // RULE17
					end
					`DTGC_OP_LOAD_LOCAL:
					begin
						if (acc[`DTGC_ACC_SEGMENT] || dtype != `DTGC_TYPE_LOCAL_TABLE)
							next_r.exc_vec = `DTGC_EXC_GENERAL; // RULE18
						else if (!acc[`DTGC_ACC_PRESENT])
							next_r.exc_vec = `DTGC_EXC_NOT_PRESENT;
						else
						begin
							next_r.ldt_limit = r.word0; // RULE20
							next_r.ldt_base = {r.word2[7:0], r.word1}; // RULE20
						end
					end
					`DTGC_OP_LOAD_SEG:
					begin
						if (!acc[`DTGC_ACC_SEGMENT]) // RULE10 RULE7
							next_r.exc_vec = `DTGC_EXC_GENERAL;
						else if (!acc[`DTGC_ACC_PRESENT])
							next_r.exc_vec = `DTGC_EXC_NOT_PRESENT;
						else
						begin
							next_r.cache[r.seg].valid = 1'b1; // RULE8
							next_r.cache[r.seg].limit = r.word0; // RULE8
							next_r.cache[r.seg].base = {r.word2[7:0], r.word1}; // RULE8
							next_r.cache[r.seg].access = acc; // RULE8
						end
					end
					default:
					begin
						if (!r.phase)
						begin
							// Vector entries come from the interrupt table, not GLOBAL_DESCRIPTOR_TABLE or LOCAL_DESCRIPTOR_TABLE
							if (r.op == `DTGC_OP_VECTOR_GATE)
								table_bad = dtype == `DTGC_TYPE_CALL_GATE;
							else if (r.sel[`DTGC_SEL_TABLE])
								table_bad = dtype == `DTGC_TYPE_INT_GATE
									|| dtype == `DTGC_TYPE_TRAP_GATE; // RULE15
							else
								table_bad = dtype == `DTGC_TYPE_INT_GATE
									|| dtype == `DTGC_TYPE_TRAP_GATE; // RULE15
							hit = locate(r.word1, r.gdt_base, r.gdt_limit, r.ldt_base,
								r.ldt_limit);
							if (!is_gate(acc) || table_bad)
								next_r.exc_vec = `DTGC_EXC_GENERAL;
							else if (!acc[`DTGC_ACC_PRESENT])
								next_r.exc_vec = `DTGC_EXC_NOT_PRESENT; // RULE6
							else if (hit[24])
								next_r.exc_vec = `DTGC_EXC_GENERAL; // RULE14
							else
							begin
								next_r.gate_kind = dtype[2:0]; // RULE1
								next_r.gate_sel = r.word1; // RULE19
								next_r.gate_off = dtype == `DTGC_TYPE_TASK_GATE
									? 16'h0000 : r.word0; // RULE4 RULE19
								next_r.copy_cnt = (dtype == `DTGC_TYPE_CALL_GATE
									&& r.priv_change) ? r.word2[4:0] : 5'h00; // RULE5
								next_r.dest_sel = r.word1;
								next_r.phase = 1'b1;
								next_r.word_cnt = 2'h0;
								next_r.mem_addr = hit[23:0];
								next_r.mem_req = 1'b1;
								next_r.busy = 1'b1;
								next_r.done = 1'b0;
								next_r.state = dtgc_pkg::ST_FETCH;
							end
						end
						else if ({1'b0, r.gate_kind} == `DTGC_TYPE_TASK_GATE)
						begin
							if (acc[`DTGC_ACC_SEGMENT] || (dtype != `DTGC_TYPE_TSS_FREE
								&& dtype != `DTGC_TYPE_TSS_BUSY)) // RULE4
								next_r.exc_vec = `DTGC_EXC_GENERAL;
						end
						else if (!acc[`DTGC_ACC_SEGMENT] || !acc[`DTGC_ACC_EXEC]) // RULE3
							next_r.exc_vec = `DTGC_EXC_GENERAL;
						else if ({1'b0, r.gate_kind} == `DTGC_TYPE_INT_GATE)
							next_r.if_flag = 1'b0; // RULE2
					end
				endcase
				if (next_r.exc_vec != 8'h00)
				begin
					next_r.exc_pulse = 1'b1;
					next_r.exc_flag = 1'b1;
					next_r.copy_cnt = 5'h00;
				end
			end

			default:
				next_r.state = dtgc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			r <= '0;
		else
			r <= next_r;
	end

	assign reg_rdata_out = r.rdata;
	assign mem_req_out = r.mem_req;
	assign mem_addr_out = r.mem_addr;
	assign phys_valid_out = r.phys_valid;
	assign phys_fault_out = r.phys_fault;
	assign phys_addr_out = r.phys_addr;
	assign busy_out = r.busy;
	assign exc_pulse_out = r.exc_pulse;
	assign exc_vector_out = r.exc_vec;
	assign if_flag_out = r.if_flag;
	assign gate_copy_count_out = r.copy_cnt;

endmodule
`default_nettype wire

// ---- tb/descriptor_table_gate_check_props.sv ----
// Port checker for the descriptor table and gate check block
`timescale 1ns/10ps
`default_nettype none
module dtgc_props (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic mem_req_out,
	input wire logic [23:0] mem_addr_out,
	input wire logic mem_ack_in,
	input wire logic ref_valid_in,
	input wire logic phys_valid_out,
	input wire logic busy_out,
	input wire logic exc_pulse_out,
	input wire logic [7:0] exc_vector_out,
	input wire logic if_flag_out
);
	logic [1:0] words;
	// Position within a three-word fetch, so the step check skips the jump to a new entry
	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			words <= 2'h0;
		else if (mem_req_out && mem_ack_in)
			words <= (words == 2'h2) ? 2'h0 : words + 2'h1;
	end
	default clocking dc @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	sequence word_taken;
		mem_req_out && mem_ack_in && words != 2'h2;
	endsequence
	sequence next_word;
		mem_req_out && mem_addr_out == $past(mem_addr_out) + 24'h000002;
	endsequence
	rdata_idle_a: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h00000000)
		else $error("read data outside answer cycle");
	phys_answer_a: assert property (ref_valid_in |=> phys_valid_out)
		else $error("translation not answered");
	phys_quiet_a: assert property (!ref_valid_in |=> !phys_valid_out)
		else $error("spurious translation answer");
	req_hold_a: assert property (mem_req_out && !mem_ack_in
		|=> mem_req_out && $stable(mem_addr_out)) else $error("fetch request dropped");
	word_step_a: assert property (word_taken |=> next_word)
		else $error("fetch address did not step by two");
	exc_code_a: assert property (exc_pulse_out
		|-> (exc_vector_out == 8'h0B || exc_vector_out == 8'h0D) ##1 !exc_pulse_out)
		else $error("bad exception pulse");
	idle_fetch_a: assert property (!busy_out |-> !mem_req_out)
		else $error("memory read while idle");
	if_hold_a: assert property (!$past(reg_write_in) && !$past(busy_out)
		&& !$past(busy_out, 2) |-> $stable(if_flag_out)) else $error("flag moved unasked");
endmodule
bind descriptor_table_gate_check dtgc_props chk (.mclk_in(mclk_in), .reset_in(reset_in),
	.reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
	.mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in),
	.ref_valid_in(ref_valid_in), .phys_valid_out(phys_valid_out), .busy_out(busy_out),
	.exc_pulse_out(exc_pulse_out), .exc_vector_out(exc_vector_out), .if_flag_out(if_flag_out));
`default_nettype wire

// ---- tb/desc_memory_model.sv ----
// Descriptor memory answering word reads with random stalls
`timescale 1ns/10ps
`default_nettype none
module desc_memory_model (
	input wire logic mclk_in,
	input wire logic mem_req_out,
	input wire logic [23:0] mem_addr_out,
	output logic [15:0] mem_rdata_in,
	output logic mem_ack_in
);
	logic [15:0] cells [int];
	logic [15:0] last = 16'h0000;
	task put(input int a, input logic [15:0] v);
		cells[a] = v;
	endtask
	// Outside an answer the data lines carry the inverse, so stale words never look valid
	always @(posedge mclk_in)
	begin
		if (mem_req_out && !mem_ack_in && ($urandom % 3 != 0))
		begin
			last = cells.exists(int'(mem_addr_out)) ? cells[int'(mem_addr_out)] : 16'h0000;
			mem_rdata_in <= last;
			mem_ack_in <= 1'b1;
		end
		else
		begin
			mem_rdata_in <= ~last;
			mem_ack_in <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- tb/test_descriptor_table_gate_check.sv ----
// Self-checking bench for the descriptor table and gate check block
`timescale 1ns/10ps
`default_nettype none
module test_descriptor_table_gate_check;
	logic mclk_in = 1'b0, reset_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
	logic ref_valid_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h00000000;
	logic [1:0] ref_seg_in = 2'h0;
	logic [15:0] ref_offset_in = 16'h0000;
	logic [31:0] reg_rdata_out, d;
	logic mem_req_out, mem_ack_in, phys_valid_out, phys_fault_out, busy_out;
	logic exc_pulse_out, if_flag_out;
	logic [23:0] mem_addr_out, phys_addr_out;
	logic [15:0] mem_rdata_in;
	logic [7:0] exc_vector_out;
	logic [4:0] gate_copy_count_out;
	int n_fail = 0, tests_run = 0, cyc = 0, off;
	// Reference copy of table bases and segment caches, rebuilt from descriptor memory
	int m_gb = 0, m_lb = 0, m_op = 0, m_base [4], m_lim [4];
	bit m_ok [4];
	always #4 mclk_in = ~mclk_in;
	descriptor_table_gate_check dut (.*);
	desc_memory_model mem (.*);
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			end_sim();
		end
	end
	task wr(input logic [7:0] a, input logic [31:0] v);
		if (a == 8'h08)
			m_op = int'(v[23:0]);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_write_in <= 1'b1;
		@(posedge mclk_in);
		reg_write_in <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge mclk_in);
		reg_read_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask
	task desc(input int a, input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
		mem.put(a, w0);
		mem.put(a + 2, w1);
		mem.put(a + 4, w2);
	endtask
	function automatic int word_at(input int a);
		return mem.cells.exists(a) ? int'(mem.cells[a]) : 0;
	endfunction
	// Base is the second word plus the low byte of the third word times 65536
	function automatic int base_at(input int a);
		return word_at(a + 2) + (word_at(a + 4) % 256) * 65536;
	endfunction
	// Runs one command and compares the status vector with the expected exception
	task cmd(input logic [31:0] c, input logic [15:0] s, input logic [7:0] v);
		int k, e;
		wr(8'h04, {16'h0000, s});
		wr(8'h00, c);
		k = 0;
		repeat (2) @(posedge mclk_in);
		#1;
		while (busy_out !== 1'b0 && k < 300)
		begin
			@(posedge mclk_in);
			#1;
			k++;
		end
		repeat (2) @(posedge mclk_in);
		rd(8'h00);
		check("status", d[8:0], {v != 8'h00, v});
		check("busy_done", d[10:9], 2'b01);
		check("exc_vector", exc_vector_out, v);
		e = (s[2] ? m_lb : m_gb) + int'(s[15:3]) * 8;
		if (v == 8'h00 && c[2:0] == 3'h2)
			m_gb = base_at(m_op);
		if (v == 8'h00 && c[2:0] == 3'h3)
			m_lb = base_at(e);
		if (v == 8'h00 && c[2:0] == 3'h0)
		begin
			m_ok[c[5:4]] = 1'b1;
			m_lim[c[5:4]] = word_at(e);
			m_base[c[5:4]] = base_at(e);
		end
	endtask
	task xl(input logic [1:0] s, input logic [15:0] o, input int b, input logic f);
		@(posedge mclk_in);
		ref_valid_in <= 1'b1;
		ref_seg_in <= s;
		ref_offset_in <= o;
		@(posedge mclk_in);
		ref_valid_in <= 1'b0;
		#1;
		check("phys_valid", phys_valid_out, 1'b1);
		check("phys_fault", phys_fault_out, f);
		if (!f)
			check("phys_addr", phys_addr_out, b + int'(o));
		check("fault_model", phys_fault_out, !m_ok[s] || int'(o) > m_lim[s]);
		if (m_ok[s] && int'(o) <= m_lim[s])
			check("addr_model", phys_addr_out, m_base[s] + int'(o));
	endtask
	initial
	begin
		off = $urandom(68501);
		desc(32'h1000, 16'h004F, 16'h2000, 16'h0001);
		desc(32'h12008, 16'h00FF, 16'h4560, 16'h9203);
		desc(32'h12018, 16'hFFFF, 16'h0000, 16'h9A05);
		desc(32'h12020, 16'h1234, 16'h0018, 16'h8405);
		desc(32'h12028, 16'h1234, 16'h0018, 16'h0405);
		desc(32'h12030, 16'h1234, 16'h0008, 16'h8403);
		desc(32'h12038, 16'h0067, 16'h0000, 16'h8106);
		desc(32'h12048, 16'h000F, 16'h0000, 16'h8202);
		desc(32'h20000, 16'h0FFF, 16'h0000, 16'h920A);
		for (int t = 4; t < 8; t++)
			desc(32'h30000 + t * 8, 16'hBEEF, (t == 5) ? 16'h0038 : 16'h0018,
				{8'h80 | 8'(t), 8'h07});
		mem.put(32'h1200E, 16'hFFFF);
		repeat (8) @(posedge mclk_in);
		reset_in <= 1'b0;
		rd(8'hF0);
		check("unmapped", d, 32'h0);
		xl(2'h1, 16'h0000, 0, 1'b1);
		wr(8'h0C, 32'h3);
		wr(8'h08, 32'h1000);
		cmd(32'h2, 16'h0, 8'h0D);
		wr(8'h0C, 32'h10);
		cmd(32'h2, 16'h0, 8'h00);
		wr(8'h10, 32'h0);
		rd(8'h10);
		check("gdt_base", d, 32'h012000);
		check("gdt_base_model", d, m_gb);
		cmd(32'h10, 16'h0008, 8'h00);
		mem.put(32'h1200A, 16'h0000);
		repeat (4)
		begin
			off = $urandom % 256;
			xl(2'h1, off[15:0], 32'h034560, 1'b0);
		end
		xl(2'h1, 16'h0100, 0, 1'b1);
		cmd(32'h30, 16'h0020, 8'h0D);
		cmd(32'h30, 16'h0050, 8'h0D);
		cmd(32'h3, 16'h0048, 8'h00);
		rd(8'h18);
		check("ldt_base", d, 32'h020000);
		check("ldt_base_model", d, m_lb);
		cmd(32'h3, 16'h004C, 8'h0D);
		cmd(32'h30, 16'h0004, 8'h00);
		xl(2'h3, 16'h0FFF, 32'h0A0000, 1'b0);
		cmd(32'h101, 16'h0023, 8'h00);
		check("copy_count", gate_copy_count_out, 5'h05);
		rd(8'h20);
		check("gate_ptr", d, 32'h12340018);
		rd(8'h24);
		check("gate_info", d, {14'h0, 2'h3, 3'h0, 5'h05, 5'h00, 3'h4});
		cmd(32'h1, 16'h0020, 8'h00);
		check("copy_count", gate_copy_count_out, 5'h00);
		cmd(32'h1, 16'h0028, 8'h0B);
		cmd(32'h1, 16'h0030, 8'h0D);
		for (int t = 4; t < 8; t++)
		begin
			wr(8'h0C, 32'h10);
			wr(8'h08, 32'h30000 + t * 8);
			cmd(32'h4, 16'h0, (t == 4) ? 8'h0D : 8'h00);
			check("if_flag", if_flag_out, t != 6);
			if (t != 4)
			begin
				check("copy_count", gate_copy_count_out, 5'h00);
				rd(8'h24);
				check("gate_kind", d[2:0], t);
				rd(8'h20);
				check("gate_offset", d[31:16], (t == 5) ? 16'h0000 : 16'hBEEF);
			end
		end
		end_sim();
	end
endmodule
`default_nettype wire
